// File: common/diw_pkg.sv
package diw_pkg;

  // clock and strap detection timing
  localparam int CLK_MHZ = 100;
  localparam int STRAP_DRIVE_NS = 200;
  localparam int STRAP_SENSE_NS = 300;
  localparam int STRAP_DRIVE_CYC = (STRAP_DRIVE_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_SENSE_CYC = (STRAP_SENSE_NS * CLK_MHZ + 999) / 1000;

  // strap states
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // slave addresses, index is high strap * 3 + low strap
  localparam logic [8:0][6:0] STRAP_ADDR_MAP = {7'h30, 7'h23, 7'h22, 7'h21, 7'h20, 7'h13, 7'h12, 7'h11, 7'h10};
  localparam logic [6:0] GLOBAL_ADDR = 7'h73;

  // transfer framing
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] DATA_BYTES = 3'h3;

  // command nibble codes
  localparam logic [3:0] CMD_WRITE = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
  localparam logic [3:0] CMD_REF_INT = 4'h6;
  localparam logic [3:0] CMD_REF_EXT = 4'h7;

  // power-on codes, left-aligned 16-bit words
  localparam logic [15:0] ZERO_SCALE_WORD = 16'h0000;
  localparam logic [15:0] MID_SCALE_WORD = 16'h8000;

  // register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INPUT = 8'h08;
  localparam logic [7:0] REG_DAC = 8'h0c;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic CTRL_RESET = 1'h1;
  localparam int CTRL_EN_BIT = 0;
  localparam int ST_PD_BIT = 0;
  localparam int ST_REFI_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_READY_BIT = 3;
  localparam int ST_ADDR_LSB = 8;
  localparam int CMD_COUNT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // filtered line levels and events
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } diw_line_t;

  // converter controls
  typedef struct packed {
    logic [15:0] input_word;
    logic [15:0] dac_word;
    logic power_down;
    logic ref_internal;
  } diw_conv_t;

  // strap pair to slave address
  function automatic logic [6:0] strap_addr(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] idx;
    idx = 4'({2'h0, hi} * 4'h3 + {2'h0, lo});
    return STRAP_ADDR_MAP[idx];
  endfunction : strap_addr

  // register address decode
  function automatic logic reg_mapped(input logic [7:0] a);
    return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_INPUT) || (a == REG_DAC) || (a == REG_CMD);
  endfunction : reg_mapped

endpackage : diw_pkg

// File: rtl/diw_pin_sync.sv
`timescale 1ns/1ps
module diw_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // system
  input wire logic clock,
  input wire logic srst,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  // filtered levels
  output logic [WIDTH-1:0] filt_out
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // three-stage synchroniser
  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // level moves only when stages two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      filt_out <= RESET_VAL;
    end else begin
      filt_out <= (s2_reg & s3_reg) | (filt_out & (s2_reg ^ s3_reg));
    end
  end

endmodule : diw_pin_sync

// File: rtl/diw_strap_detect.sv
`timescale 1ns/1ps
module diw_strap_detect
  import diw_pkg::*;
#(
  parameter int PINS = 2
) (
  // system
  input wire logic clock,
  input wire logic srst,
  // strap pins
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  // result
  output logic [PINS-1:0][1:0] strap,
  output logic done
);

  typedef enum logic [2:0] {PH_DRV_LO, PH_SNS_LO, PH_DRV_HI, PH_SNS_HI, PH_DONE} diw_phase_t;

  localparam logic [7:0] DRIVE_LAST = 8'(STRAP_DRIVE_CYC - 1);
  localparam logic [7:0] SENSE_LAST = 8'(STRAP_SENSE_CYC - 1);

  diw_phase_t phase_reg;
  logic [7:0] cnt_reg;
  logic [PINS-1:0] filt;
  logic [PINS-1:0] seen_lo_reg;
  logic sense_end;

  diw_pin_sync #(.WIDTH(PINS), .RESET_VAL({PINS{1'b0}})) u_sync (
    .clock(clock),
    .srst(srst),
    .pin_in(pin_in),
    .filt_out(filt)
  );

  assign sense_end = cnt_reg == SENSE_LAST;

  // drive low, release, drive high, release, then hold the result
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_reg <= PH_DRV_LO;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      case (phase_reg)
        PH_DRV_LO: if (cnt_reg == DRIVE_LAST) begin
          phase_reg <= PH_SNS_LO;
          cnt_reg <= 8'h00;
        end
        PH_SNS_LO: if (sense_end) begin
          phase_reg <= PH_DRV_HI;
          cnt_reg <= 8'h00;
        end
        PH_DRV_HI: if (cnt_reg == DRIVE_LAST) begin
          phase_reg <= PH_SNS_HI;
          cnt_reg <= 8'h00;
        end
        PH_SNS_HI: if (sense_end) begin
          phase_reg <= PH_DONE;
          cnt_reg <= 8'h00;
        end
        PH_DONE: cnt_reg <= 8'h00;
        default: phase_reg <= PH_DRV_LO;
      endcase
    end
  end

  // pin level left behind after a low drive
  always_ff @(posedge clock) begin
    if (srst) begin
      seen_lo_reg <= '0;
    end else if (phase_reg == PH_SNS_LO && sense_end) begin
      seen_lo_reg <= filt;
    end
  end

  // a pin that keeps whatever was last driven is floating
  always_ff @(posedge clock) begin
    if (srst) begin
      strap <= '0;
    end else if (phase_reg == PH_SNS_HI && sense_end) begin
      for (int i = 0; i < PINS; i++) begin
        if (seen_lo_reg[i] && filt[i]) strap[i] <= STRAP_HIGH;
        else if (!seen_lo_reg[i] && !filt[i]) strap[i] <= STRAP_LOW;
        else strap[i] <= STRAP_FLOAT;
      end
    end
  end

  // pins driven only in the drive phases
  assign pin_out = {PINS{phase_reg == PH_DRV_HI}};
  assign pin_oe_n = {PINS{!(phase_reg == PH_DRV_LO || phase_reg == PH_DRV_HI)}};
  assign done = phase_reg == PH_DONE;

endmodule : diw_strap_detect

// File: rtl/diw_write_slave.sv
`timescale 1ns/1ps
module diw_write_slave
  import diw_pkg::*;
#(
  parameter int CODE_BITS = 12,
  parameter bit TWO_PINS = 1'b1,
  parameter bit MID_RESET = 1'b0
) (
  // system
  input wire logic clock,
  input wire logic srst,
  // serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // address straps and reference default
  input wire logic addr_strap_low_in,
  output logic addr_strap_low_out,
  output logic addr_strap_low_oe_n,
  input wire logic addr_strap_high_in,
  output logic addr_strap_high_out,
  output logic addr_strap_high_oe_n,
  input wire logic ref_default_in,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter side
  output diw_conv_t conv
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_DATA, S_HOLD, S_ACK, S_IGNORE} diw_state_t;

  localparam logic [15:0] CODE_MASK = ~(16'hffff >> CODE_BITS);
  localparam logic [15:0] RESET_WORD = MID_RESET ? MID_SCALE_WORD : ZERO_SCALE_WORD;

  logic [2:0] filt;
  logic scl_prev_reg;
  logic sda_prev_reg;
  diw_line_t line;
  logic [1:0][1:0] strap;
  logic strap_done;
  logic init_done_reg;
  logic [6:0] own_addr;
  diw_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic in_addr_reg;
  logic ack_en_reg;
  logic [23:0] word_reg;
  logic [23:0] word_next;
  logic sda_oe_n_reg;
  logic exec_reg;
  logic [23:0] cmd_word_reg;
  logic [7:0] exec_count_reg;
  logic [15:0] code;
  logic [15:0] input_word_reg;
  logic [15:0] dac_word_reg;
  logic power_down_reg;
  logic ref_internal_reg;
  logic ctrl_reg;
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rd_word;
  logic go;

  // scl, sda and reference default through the filter
  diw_pin_sync #(.WIDTH(3), .RESET_VAL(3'b111)) u_line_sync (
    .clock(clock),
    .srst(srst),
    .pin_in({ref_default_in, sda_in, scl_in}),
    .filt_out(filt)
  );

  // strap detection right after reset
  diw_strap_detect #(.PINS(2)) u_strap (
    .clock(clock),
    .srst(srst),
    .pin_in({addr_strap_high_in, addr_strap_low_in}),
    .pin_out({addr_strap_high_out, addr_strap_low_out}),
    .pin_oe_n({addr_strap_high_oe_n, addr_strap_low_oe_n}),
    .strap(strap),
    .done(strap_done)
  );

  // previous filtered levels
  always_ff @(posedge clock) begin
    if (srst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= filt[0];
      sda_prev_reg <= filt[1];
    end
  end

  // bus events from filtered levels
  always_comb begin
    line.scl = filt[0];
    line.sda = filt[1];
    line.scl_rise = filt[0] && !scl_prev_reg;
    line.scl_fall = !filt[0] && scl_prev_reg;
    line.start = scl_prev_reg && filt[0] && sda_prev_reg && !filt[1];
    line.stop = scl_prev_reg && filt[0] && !sda_prev_reg && filt[1];
  end

  // own address, single-strap variant reads the high strap as low
  assign own_addr = strap_addr(TWO_PINS ? strap[1] : STRAP_LOW, strap[0]);
  assign word_next = {word_reg[22:0], line.sda};
  assign go = ctrl_reg && init_done_reg;

  // power-up phase ends when straps are known
  always_ff @(posedge clock) begin
    if (srst) begin
      init_done_reg <= 1'b0;
    end else if (strap_done) begin
      init_done_reg <= 1'b1;
    end
  end

  // serial receive state machine
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg <= S_IDLE;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 3'h0;
      in_addr_reg <= 1'b0;
      ack_en_reg <= 1'b0;
      word_reg <= 24'h000000;
      sda_oe_n_reg <= 1'b1;
      exec_reg <= 1'b0;
      cmd_word_reg <= 24'h000000;
    end else begin
      exec_reg <= 1'b0;
      if (line.stop || !go) begin
        state_reg <= S_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (line.start) begin
        state_reg <= S_ADDR;
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 3'h0;
        in_addr_reg <= 1'b1;
        sda_oe_n_reg <= 1'b1;
      end else begin
        case (state_reg)
          S_ADDR, S_DATA: if (line.scl_rise) begin
            word_reg <= word_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == LAST_BIT) begin
              state_reg <= S_HOLD;
              if (in_addr_reg) begin
                // write direction to own or global address only
                ack_en_reg <= (word_next[7:1] == own_addr || word_next[7:1] == GLOBAL_ADDR)
                  && !word_next[0];
              end else begin
                ack_en_reg <= byte_cnt_reg < DATA_BYTES;
                if (byte_cnt_reg != 3'h4) byte_cnt_reg <= byte_cnt_reg + 3'h1;
                if (byte_cnt_reg == DATA_BYTES - 3'h1) begin
                  exec_reg <= 1'b1;
                  cmd_word_reg <= word_next;
                end
              end
            end
          end
          S_HOLD: if (line.scl_fall) begin
            state_reg <= S_ACK;
            sda_oe_n_reg <= !ack_en_reg;
          end
          S_ACK: if (line.scl_fall) begin
            sda_oe_n_reg <= 1'b1;
            state_reg <= (in_addr_reg && !ack_en_reg) ? S_IGNORE : S_DATA;
            in_addr_reg <= 1'b0;
            bit_cnt_reg <= 3'h0;
          end
          S_IDLE, S_IGNORE: state_reg <= state_reg;
          default: state_reg <= S_IDLE;
        endcase
      end
    end
  end

  // code field, msb first, trailing bits dropped
  assign code = cmd_word_reg[15:0] & CODE_MASK;

  // command execution and power-on defaults
  always_ff @(posedge clock) begin
    if (srst) begin
      input_word_reg <= RESET_WORD;
      dac_word_reg <= RESET_WORD;
      power_down_reg <= 1'b0;
      ref_internal_reg <= 1'b1;
      exec_count_reg <= 8'h00;
    end else if (strap_done && !init_done_reg) begin
      ref_internal_reg <= MID_RESET ? filt[2] : 1'b1;
    end else if (exec_reg) begin
      exec_count_reg <= exec_count_reg + 8'h01;
      case (cmd_word_reg[23:20])
        CMD_WRITE: input_word_reg <= code;
        CMD_UPDATE: begin
          dac_word_reg <= input_word_reg;
          power_down_reg <= 1'b0;
        end
        CMD_WRITE_UPDATE: begin
          input_word_reg <= code;
          dac_word_reg <= code;
          power_down_reg <= 1'b0;
        end
        CMD_POWER_DOWN: power_down_reg <= 1'b1;
        CMD_REF_INT: ref_internal_reg <= 1'b1;
        CMD_REF_EXT: ref_internal_reg <= 1'b0;
        default: power_down_reg <= power_down_reg;
      endcase
    end
  end

  // receiver never drives a one
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_reg;
  assign conv = '{input_word: input_word_reg, dac_word: dac_word_reg,
                  power_down: power_down_reg, ref_internal: ref_internal_reg};

  // axi write channels, address and data in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_held_reg && w_held_reg && !bvalid_reg) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= reg_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr_reg == REG_CTRL && w_strb_reg[0]) ctrl_reg <= w_data_reg[CTRL_EN_BIT];
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // read word select
  always_comb begin
    rd_word = 32'h00000000;
    case (s_axi_araddr)
      REG_CTRL: rd_word[CTRL_EN_BIT] = ctrl_reg;
      REG_STATUS: begin
        rd_word[ST_PD_BIT] = power_down_reg;
        rd_word[ST_REFI_BIT] = ref_internal_reg;
        rd_word[ST_BUSY_BIT] = state_reg != S_IDLE;
        rd_word[ST_READY_BIT] = init_done_reg;
        rd_word[ST_ADDR_LSB +: 7] = own_addr;
      end
      REG_INPUT: rd_word[15:0] = input_word_reg;
      REG_DAC: rd_word[15:0] = dac_word_reg;
      REG_CMD: begin
        rd_word[3:0] = cmd_word_reg[23:20];
        rd_word[CMD_COUNT_LSB +: 8] = exec_count_reg;
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // axi read channel, answer one cycle after the address
  assign s_axi_arready = !rvalid_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  bit_sample_a: assert property ((state_reg == S_ADDR || state_reg == S_DATA) && line.scl_rise && go && !line.stop
    |=> word_reg[0] == $past(line.sda)) else $error("bit not sampled on clock rise");
  drive_slot_a: assert property (!sda_oe_n_reg |-> state_reg == S_ACK)
    else $error("data driven outside acknowledge slot");
  start_addr_a: assert property (line.start && go && !line.stop
    |=> state_reg == S_ADDR && bit_cnt_reg == 3'h0 && sda_oe_n_reg) else $error("start not taken");
  stop_idle_a: assert property (line.stop |=> state_reg == S_IDLE && sda_oe_n_reg)
    else $error("stop not taken");
  ack_given_a: assert property (state_reg == S_HOLD && line.scl_fall && ack_en_reg && go && !line.stop
    |=> !sda_oe_n_reg) else $error("acknowledge not driven");
  ack_hold_a: assert property (state_reg == S_ACK && !sda_oe_n_reg && line.scl && go && !line.stop && !line.start
    |=> !sda_oe_n_reg) else $error("acknowledge dropped while clock high");
  read_nack_a: assert property (state_reg == S_ACK && in_addr_reg && word_reg[0] |-> sda_oe_n_reg)
    else $error("read request acknowledged");
  addr_match_a: assert property (state_reg == S_HOLD && in_addr_reg |-> ack_en_reg ==
    ((word_reg[7:1] == own_addr || word_reg[7:1] == GLOBAL_ADDR) && !word_reg[0])) else $error("address match wrong");
  extra_nack_a: assert property (state_reg == S_ACK && !in_addr_reg && byte_cnt_reg > DATA_BYTES
    |-> sda_oe_n_reg) else $error("extra byte acknowledged");
  exec_third_a: assert property (exec_reg |-> byte_cnt_reg == DATA_BYTES && state_reg == S_HOLD)
    else $error("execute not on third byte");
  write_input_a: assert property (exec_reg && cmd_word_reg[23:20] == CMD_WRITE
    |=> conv.input_word == ($past(cmd_word_reg[15:0]) & CODE_MASK)) else $error("input write wrong");
  update_dac_a: assert property (exec_reg && cmd_word_reg[23:20] == CMD_UPDATE
    |=> conv.dac_word == $past(conv.input_word) && !conv.power_down) else $error("update wrong");
  por_code_a: assert property ($fell(srst) |-> conv.dac_word == RESET_WORD && conv.input_word == RESET_WORD)
    else $error("power-on code wrong");
  ref_por_a: assert property (strap_done && !init_done_reg
    |=> conv.ref_internal == (MID_RESET ? $past(filt[2]) : 1'b1)) else $error("power-on reference wrong");
  ref_lock_a: assert property (init_done_reg && !exec_reg |=> $stable(conv.ref_internal))
    else $error("reference changed without command");

  exec_seen_c: cover property (exec_reg);
  read_refused_c: cover property (state_reg == S_ACK && in_addr_reg && word_reg[0]);
  extra_byte_c: cover property (state_reg == S_ACK && byte_cnt_reg > DATA_BYTES);
  ref_ext_c: cover property (exec_reg && cmd_word_reg[23:20] == CMD_REF_EXT);

endmodule : diw_write_slave

// File: tb/diw_i2c_master.sv
`timescale 1ns/1ps
module diw_i2c_master (
  // system
  input wire logic clock,
  // wired-and data line
  input wire logic sda_bus,
  // driven lines
  output logic scl,
  output logic sda
);
  logic last;
  // both lines idle high
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    last = 1'b1;
  end
  // one quarter of a bit, 40 ns
  task automatic q(input logic c, input logic d);
    @(posedge clock);
    scl <= c;
    sda <= d;
    repeat (3) @(posedge clock);
  endtask : q
  // data moves only while clock is low
  task automatic bit_io(input logic d, output logic s);
    q(1'b0, last);
    q(1'b0, d);
    q(1'b1, d);
    @(negedge clock);
    s = sda_bus;
    q(1'b1, d);
    last = d;
  endtask : bit_io
  // data falls with clock high
  task automatic start();
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    last = 1'b0;
  endtask : start
  // data rises with clock high
  task automatic stop();
    q(1'b0, last);
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    repeat (3) q(1'b1, 1'b1);
    last = 1'b1;
  endtask : stop
  // byte msb first, data released in the ack slot
  task automatic xfer(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : xfer
endmodule : diw_i2c_master

// File: tb/diw_write_slave_bench.sv
`timescale 1ns/1ps
module diw_write_slave_bench;
  import diw_pkg::*;
  logic clock, srst, scl, m_sda, sda_out, sda_oe_n, sda_bus;
  logic strap_out, strap_oe_n, strap_keep, sda_out_m, sda_oe_n_m;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  diw_conv_t conv, conv_m;
  int fail_count, n_checks;
  // open-drain data line with pull-up
  assign sda_bus = m_sda & (sda_oe_n | sda_out) & (sda_oe_n_m | sda_out_m);
  diw_i2c_master m_u (.clock(clock), .sda_bus(sda_bus), .scl(scl), .sda(m_sda));
  // first strap floats, second tied low: address 0x11
  diw_write_slave dut_u (.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap_low_in(strap_keep), .addr_strap_low_out(strap_out),
    .addr_strap_low_oe_n(strap_oe_n),
    .addr_strap_high_in(1'b0), .addr_strap_high_out(), .addr_strap_high_oe_n(), .ref_default_in(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .conv(conv));
  // floating strap keeps the level last driven onto it
  always @(posedge clock) begin
    if (!strap_oe_n) strap_keep <= strap_out;
  end
  // mid-reset, single strap tied high (0x12), 8-bit code, external default reference
  diw_write_slave #(.CODE_BITS(8), .TWO_PINS(1'b0), .MID_RESET(1'b1)) dut_mid_u (.clock(clock), .srst(srst),
    .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out_m), .sda_oe_n(sda_oe_n_m), .addr_strap_low_in(1'b1),
    .addr_strap_low_out(), .addr_strap_low_oe_n(), .addr_strap_high_in(1'b0), .addr_strap_high_out(),
    .addr_strap_high_oe_n(), .ref_default_in(1'b0), .s_axi_awaddr(8'h00), .s_axi_awvalid(1'b0),
    .s_axi_awready(), .s_axi_wdata(32'h00000000), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0), .s_axi_wready(),
    .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0), .s_axi_araddr(8'h00), .s_axi_arvalid(1'b0),
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0), .conv(conv_m));
  // 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // one axi4-lite write or read, each channel released when taken
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [33:0] res);
    logic aw, w, ar, b, rv;
    int n;
    @(posedge clock);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 50; n++) begin
      @(negedge clock);
      {aw, w, ar} = {awvalid & awready, wvalid & wready, arvalid & arready};
      {b, rv} = {bvalid & bready, rvalid & rready};
      res = wr ? {32'h0, bresp} : {rdata, rresp};
      @(posedge clock);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
      if (ar) arvalid <= 1'b0;
      if (b) bready <= 1'b0;
      if (rv) rready <= 1'b0;
      if (b | rv) break;
    end
    if (n == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask : bus
  // one frame: start, nb bytes from the top of m, stop
  task automatic send(input logic [39:0] m, input int nb, output logic [4:0] acks);
    logic a;
    acks = 5'h0;
    m_u.start();
    for (int i = 0; i < nb; i++) begin
      m_u.xfer(m[39-8*i -: 8], a);
      acks[4-i] = a;
    end
    m_u.stop();
  endtask : send
  // command table on the global address, expected converter state after each
  logic [3:0] cm[6] = '{4'h0, 4'h1, 4'h4, 4'h3, 4'h7, 4'h6};
  logic [15:0] dt[6] = '{16'h1234, 16'h0, 16'h0, 16'h5678, 16'h0, 16'h0};
  logic [33:0] ex[6] = '{{32'h1230abc0, 2'h1}, {32'h12301230, 2'h1}, {32'h12301230, 2'h3},
    {32'h56705670, 2'h1}, {32'h56705670, 2'h0}, {32'h56705670, 2'h1}};
  initial begin
    logic [4:0] acks;
    logic [33:0] res;
    {srst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (150) @(posedge clock);
    check(conv, 34'h1);
    check(conv_m, {32'h80008000, 2'h0});
    send({8'h22, 8'h30, 8'hab, 8'hcd, 8'h00}, 4, acks);
    check(acks, 5'h1e);
    check(conv, {32'habc0abc0, 2'h1});
    send({8'h23, 32'h0}, 1, acks);
    check(acks, 5'h0);
    send({8'h20, 32'h0}, 1, acks);
    check(acks, 5'h0);
    for (int k = 0; k < 6; k++) begin
      send({8'he6, cm[k], 4'h0, dt[k], 8'hff}, 5, acks);
      check(acks, 5'h1e);
      check(conv, ex[k]);
    end
    check(conv_m, {32'h56005600, 2'h1});
    // register side: status, unmapped place, slave disable
    bus(1'b0, 8'h04, 32'h0, res);
    check(res, {32'h0000110a, 2'h0});
    bus(1'b0, 8'h20, 32'h0, res);
    check(res, {32'h0, 2'h2});
    bus(1'b1, 8'h20, 32'h0, res);
    check(res, {32'h0, 2'h2});
    bus(1'b1, 8'h00, 32'h0, res);
    send({8'h22, 32'h0}, 1, acks);
    check(acks, 5'h0);
    bus(1'b1, 8'h00, 32'h1, res);
    end_of_test();
  end
endmodule : diw_write_slave_bench
